// ==== design/bcbn_core.sv ====
// decode and execute of bit clear in file and branch when negative
// assumes insn_valid_in presents one word per cycle from the fetch path
`timescale 1ns/1ns
`default_nettype none
module bcbn_core
    import bcbn_pkg::*;
(
    input  wire logic               core_clk_in,
    input  wire logic               sys_rst_in,
    input  wire logic               insn_valid_in,
    input  wire logic [INSN_W-1:0]  insn_in,
    input  wire logic               negative_flag_in,
    input  wire logic               ext_set_en_in,
    input  wire logic [3:0]         bank_select_register_in,
    input  wire logic [DADDR_W-1:0] index_base_in,
    output logic      [PC_W-1:0]    pc_out,
    output logic                    busy_out,
    output logic                    wr_en_out,
    output logic      [DADDR_W-1:0] wr_addr_out,
    output logic      [7:0]         wr_data_out
);
    typedef struct packed {
        bcbn_state_type     state;
        logic [PC_W-1:0]    pc;
        logic [DADDR_W-1:0] addr;
        logic [2:0]         bit_sel;
        logic               wr_en;
        logic [DADDR_W-1:0] wr_addr;
        logic [7:0]         wr_data;
        logic               busy;     // registered copy of the busy output
        logic               fwd;      // read of this clear overlaps the last write
    } bcbn_regs_type;

    // register set and its next value
    bcbn_regs_type r;
    bcbn_regs_type next_r;
    // raw read data from the data memory
    logic [7:0]    rd_data;
    // byte that the clear works on, memory or forwarded
    logic [7:0]    src_data;

    // write-through hazard: a clear taken right after another one reads the
    // memory at the very edge on which the earlier write lands, so the read
    // returns the old byte; the pending write data is forwarded instead

    // address formation for bit clear in file
    function automatic logic [DADDR_W-1:0] bcbn_addr(input logic [7:0] f, input logic a,
        input logic ext, input logic [3:0] bank, input logic [DADDR_W-1:0] base);
        if (a) begin
            bcbn_addr = {bank, f};
        end else if (ext && f <= INDEXED_LIMIT) begin
            bcbn_addr = base + {{(DADDR_W-8){1'b0}}, f};
        end else if (f < ACCESS_SPLIT) begin
            bcbn_addr = {4'h0, f};
        end else begin
            bcbn_addr = {SFR_BANK, f};
        end
    endfunction

    bcbn_data_ram u_ram (
        .core_clk_in (core_clk_in),
        .rd_addr_in  (next_r.addr),
        .rd_data_out (rd_data),
        .wr_en_in    (r.wr_en),
        .wr_addr_in  (r.wr_addr),
        .wr_data_in  (r.wr_data)
    );

    // next-state decode
    always_comb begin
        // forwarded byte wins when the read overlapped the previous write
        src_data     = r.fwd ? r.wr_data : rd_data;
        next_r       = r;
        next_r.wr_en = 1'b0;
        case (r.state)
            BCBN_IDLE: begin
                if (insn_valid_in) begin
                    next_r.pc = r.pc + PC_STEP;
                    if (insn_in[15:12] == OP_BIT_CLEAR) begin
                        next_r.addr    = bcbn_addr(insn_in[7:0], insn_in[8], ext_set_en_in,
                                                   bank_select_register_in, index_base_in);
                        next_r.bit_sel = insn_in[11:9];
                        next_r.fwd     = r.wr_en && (r.wr_addr == next_r.addr);
                        next_r.state   = BCBN_EXEC;
                    end else if (insn_in[15:8] == OP_BR_NEG) begin
                        if (negative_flag_in) begin
                            next_r.pc    = r.pc + PC_STEP
                                         + PC_W'({{(PC_W-9){insn_in[7]}}, insn_in[7:0], 1'b0});
                            next_r.state = BCBN_FLUSH;
                        end
                    end
                end
            end
            BCBN_EXEC: begin
                next_r.wr_en   = 1'b1;
                next_r.wr_addr = r.addr;
                next_r.wr_data = src_data & ~(8'h01 << r.bit_sel);
                next_r.state   = BCBN_IDLE;
            end
            BCBN_FLUSH: begin
                next_r.state = BCBN_IDLE;
            end
            default: next_r.state = BCBN_IDLE;
        endcase
        // busy follows the next state so that the output is a flip-flop
        next_r.busy = (next_r.state != BCBN_IDLE);
    end

    // state register
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            r <= '{BCBN_IDLE, '0, '0, 3'h0, 1'b0, '0, 8'h00, 1'b0, 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign pc_out      = r.pc;
    assign busy_out    = r.busy;
    assign wr_en_out   = r.wr_en;
    assign wr_addr_out = r.wr_addr;
    assign wr_data_out = r.wr_data;

    AST_BR_TARGET: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_IDLE && insn_valid_in && insn_in[15:8] == OP_BR_NEG && negative_flag_in
        |=> pc_out == $past(r.pc) + PC_STEP + PC_W'({{(PC_W-9){$past(insn_in[7])}},
            $past(insn_in[7:0]), 1'b0}) && r.state == BCBN_FLUSH)
        else $error("branch target wrong");
    AST_BR_NOT_TAKEN: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_IDLE && insn_valid_in && insn_in[15:8] == OP_BR_NEG && !negative_flag_in
        |=> pc_out == $past(r.pc) + PC_STEP && !busy_out)
        else $error("untaken branch moved pc wrongly");
    AST_FLUSH_ONE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_FLUSH |=> r.state == BCBN_IDLE && $stable(pc_out))
        else $error("flush not one cycle");
    AST_BC_WRITE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_EXEC |=> wr_en_out && wr_addr_out == $past(r.addr)
        && wr_data_out[$past(r.bit_sel)] == 1'b0)
        else $error("bit clear write wrong");
    AST_BC_KEEP: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_EXEC |=> (wr_data_out | (8'h01 << $past(r.bit_sel)))
        == ($past(src_data) | (8'h01 << $past(r.bit_sel))))
        else $error("other bits changed");

    // busy output must track the exec and flush states exactly
    AST_BUSY_STATE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        busy_out == (r.state != BCBN_IDLE))
        else $error("busy output out of step with state");

    // no pc movement while the clear is executing
    AST_EXEC_HOLD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_EXEC |=> $stable(pc_out))
        else $error("pc moved during bit clear");

    // a forwarded clear keeps the bits of the previous write
    AST_FWD_DATA: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_EXEC && r.fwd
        |=> (wr_data_out | (8'h01 << $past(r.bit_sel)))
        == ($past(r.wr_data) | (8'h01 << $past(r.bit_sel))))
        else $error("forwarded clear lost bits");
    AST_BANKED: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_IDLE && insn_valid_in && insn_in[15:12] == OP_BIT_CLEAR && insn_in[8]
        |=> r.addr == {$past(bank_select_register_in), $past(insn_in[7:0])})
        else $error("banked address wrong");
    AST_ACCESS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_IDLE && insn_valid_in && insn_in[15:12] == OP_BIT_CLEAR && !insn_in[8]
        && !ext_set_en_in |=> r.addr[7:0] == $past(insn_in[7:0])
        && (r.addr[11:8] == 4'h0 || r.addr[11:8] == SFR_BANK))
        else $error("access bank address wrong");
    AST_INDEXED: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_IDLE && insn_valid_in && insn_in[15:12] == OP_BIT_CLEAR && !insn_in[8]
        && ext_set_en_in && insn_in[7:0] <= INDEXED_LIMIT
        |=> r.addr == $past(index_base_in) + DADDR_W'($past(insn_in[7:0])))
        else $error("indexed address wrong");
    AST_OTHER_OP: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        r.state == BCBN_IDLE && insn_valid_in && insn_in[15:8] != OP_BR_NEG
        && insn_in[15:12] != OP_BIT_CLEAR |=> !busy_out)
        else $error("unknown opcode started work");

    COV_TAKEN: cover property (@(posedge core_clk_in) r.state == BCBN_FLUSH);
    COV_CLEAR: cover property (@(posedge core_clk_in) wr_en_out);
    COV_INDEXED: cover property (@(posedge core_clk_in) r.state == BCBN_IDLE && insn_valid_in
        && insn_in[15:12] == OP_BIT_CLEAR && !insn_in[8] && ext_set_en_in);
    // untaken branch seen
    COV_NOT_TAKEN: cover property (@(posedge core_clk_in) r.state == BCBN_IDLE && insn_valid_in
        && insn_in[15:8] == OP_BR_NEG && !negative_flag_in);
    // back to back clear with forwarding
    COV_FWD: cover property (@(posedge core_clk_in) r.state == BCBN_EXEC && r.fwd);
endmodule
`default_nettype wire

// ==== design/bcbn_pkg.sv ====
// constants for the bit-clear / branch-negative decode and execute block
// assumes 16-bit instruction words and a 21-bit byte program counter
package bcbn_pkg;
    localparam int          INSN_W        = 16;
    localparam int          PC_W          = 21;
    localparam int          DADDR_W       = 12;
    localparam logic [3:0]  OP_BIT_CLEAR  = 4'h9;   // upper nibble 1001
    localparam logic [7:0]  OP_BR_NEG     = 8'hE6;  // upper byte 1110 0110
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;  // access bank low/high split
    localparam logic [7:0]  INDEXED_LIMIT = 8'h5F;  // 95
    localparam logic [3:0]  SFR_BANK      = 4'hF;
    localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
    typedef enum logic [1:0] {BCBN_IDLE, BCBN_EXEC, BCBN_FLUSH} bcbn_state_type;
endpackage

// ==== design/bcbn_data_ram.sv ====
// banked data memory, 4k x 8, synchronous write, registered read
// assumes one read and one write port on the same clock
`timescale 1ns/1ns
`default_nettype none
module bcbn_data_ram
    import bcbn_pkg::*;
(
    input  wire logic               core_clk_in,
    input  wire logic [DADDR_W-1:0] rd_addr_in,
    output logic      [7:0]         rd_data_out,
    input  wire logic               wr_en_in,
    input  wire logic [DADDR_W-1:0] wr_addr_in,
    input  wire logic [7:0]         wr_data_in
);
    logic [7:0] mem [0:(1<<DADDR_W)-1];

    // write port and registered read port
    always_ff @(posedge core_clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule
`default_nettype wire

// ==== dv/bcbn_fetch_model.sv ====
// fetch path model: offers one instruction word at a time to the core
// assumes the caller waits until the core is idle before issuing
`timescale 1ns/1ns
`default_nettype none
module bcbn_fetch_model
    import bcbn_pkg::*;
(
    input  wire logic              core_clk_in,
    output logic                   insn_valid_out,
    output logic      [INSN_W-1:0] insn_out
);
    initial begin
        insn_valid_out = 1'b0;
        insn_out       = 16'h0000;
    end
    // present a word for one take edge, then scramble the idle bus
    task automatic issue(input logic [INSN_W-1:0] word);
        @(posedge core_clk_in);
        insn_valid_out <= 1'b1;
        insn_out       <= word;
        @(posedge core_clk_in);
        insn_valid_out <= 1'b0;
        insn_out       <= ~word;
    endtask
endmodule
`default_nettype wire

// ==== dv/bcbn_core_tb_top.sv ====
// self-checking bench for the bit clear / branch negative core
// assumes one core clock, synchronous reset, fetch model in front
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) num_checks++; if ((e) !== (g)) begin $display("ERROR %s exp %0h got %0h", nm, e, g); mismatches++; end
module bcbn_core_tb_top;
    import bcbn_pkg::*;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               vld;
    logic [INSN_W-1:0]  insn;
    logic               neg = 1'b0;
    logic               ext = 1'b0;
    logic [3:0]         bank = 4'h0;
    logic [DADDR_W-1:0] base = 12'h200;
    logic [PC_W-1:0]    pc, exp_pc;
    logic               busy, wen;
    logic [DADDR_W-1:0] waddr;
    logic [7:0]         wdata;
    int                 mismatches = 0;
    int                 num_checks = 0;
    // clock, 40 ns period
    always #20 clk = ~clk;
    bcbn_fetch_model u_fetch (.core_clk_in(clk), .insn_valid_out(vld), .insn_out(insn));
    bcbn_core u_dut (.core_clk_in(clk), .sys_rst_in(rst), .insn_valid_in(vld), .insn_in(insn),
        .negative_flag_in(neg), .ext_set_en_in(ext), .bank_select_register_in(bank),
        .index_base_in(base), .pc_out(pc), .busy_out(busy), .wr_en_out(wen),
        .wr_addr_out(waddr), .wr_data_out(wdata));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // set mode inputs at a rising edge
    task automatic cfg(input logic e, input logic [3:0] b, input logic n);
        @(posedge clk);
        ext <= e;
        bank <= b;
        neg <= n;
    endtask
    // one bit clear: busy cycle, then one write pulse
    task automatic bcf(input logic [2:0] b, input logic a, input logic [7:0] f,
                       input logic [11:0] addr);
        u_fetch.issue({OP_BIT_CLEAR, b, a, f});
        #1 exp_pc = exp_pc + PC_STEP;
        `CHK("pc", exp_pc, pc)
        `CHK("busy", 1'b1, busy)
        @(posedge clk); #1;
        `CHK("wr_en", 1'b1, wen)
        `CHK("wr_addr", addr, waddr)
        `CHK("cleared bit", 1'b0, wdata[b])
        @(posedge clk); #1;
        `CHK("wr_en pulse", 1'b0, wen)
    endtask
    // one branch word, taken or not
    task automatic br(input logic [15:0] w, input logic n, input logic tk);
        cfg(ext, bank, n);
        u_fetch.issue(w);
        #1 exp_pc = exp_pc + PC_STEP + (tk ? {{12{w[7]}}, w[7:0], 1'b0} : 21'h0);
        `CHK("pc", exp_pc, pc)
        `CHK("busy", tk, busy)
        @(posedge clk); #1;
        `CHK("busy end", 1'b0, busy)
    endtask
    task automatic t_addressing();
        cfg(1'b0, 4'h3, 1'b0);
        bcf(3'h7, 1'b0, 8'h05, 12'h005);
        bcf(3'h0, 1'b0, 8'h60, 12'hF60);
        bcf(3'h3, 1'b1, 8'h60, 12'h360);
        cfg(1'b1, 4'h3, 1'b0);
        bcf(3'h1, 1'b0, 8'h5F, 12'h25F);
        bcf(3'h2, 1'b0, 8'h60, 12'hF60);
        bcf(3'h4, 1'b1, 8'h10, 12'h310);
        for (int i = 0; i < 8; i++) bcf(i[2:0], 1'b1, 8'hAA, 12'h3AA);
        `CHK("all bits cleared", 8'h00, wdata)
        $display("test addressing done");
    endtask
    task automatic t_branch();
        br(16'hE67F, 1'b1, 1'b1);
        br(16'hE680, 1'b1, 1'b1);
        br(16'hE6FE, 1'b1, 1'b1);
        br(16'hE610, 1'b0, 1'b0);
        br(16'hE710, 1'b1, 1'b0);
        $display("test branch done");
    endtask
    // main sequence
    initial begin
        exp_pc = 21'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("reset pc", 21'h0, pc)
        `CHK("reset wr_en", 1'b0, wen)
        t_addressing();
        t_branch();
        end_sim();
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
